// >>> design/wrt_ctrl.sv
// Run mode and trigger controller in front of the waveform sequencer.
// Assumes the sequencer pulses o_cycle_done-like i_cycle_end per cycle.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Override: qualified trigger restarts waveform at once
// - Retrigger: start after finish plus gap
// - Gated: output only while trigger level active
// - Burst: count cycles per trigger or command
// - Delayed trigger waits programmed delay before start
// - Reject pulses narrower or wider than limits
// - Hold-off ignores false triggers after valid
// - Armed mode: separate start and stop sources
// - Trigger from one selected source
// - Internal generator triggers every int_period plus one cycles
module wrt_ctrl (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// Configuration
	input wire wrt_pkg::wrt_cfg_t i_cfg,
	// Trigger sources
	input wire wrt_pkg::wrt_trig_in_t i_trig,
	input wire logic i_remote_trig,
	input wire logic i_remote_arm,
	// Sequencer side
	input wire logic i_cycle_end,
	output logic o_run,
	output logic o_restart,
	// Status
	output logic o_busy,
	output logic o_armed
);
	import wrt_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_RUN, ST_GAP, ST_WAIT_STOP} wrt_state_t;

	wrt_trig_in_t clean;
	logic [2:0] level_vec;
	logic sel_level, start_level, stop_level;
	logic sel_prev_r, sel_prev_nxt;
	logic stop_prev_r, stop_prev_nxt;
	logic start_prev_r, start_prev_nxt;
	logic [CNT_W-1:0] width_r, width_nxt;
	logic [CNT_W-1:0] hold_r, hold_nxt;
	logic [CNT_W-1:0] per_r, per_nxt;
	logic int_tick;
	logic qual_trig;
	logic start_edge, stop_edge;
	wrt_state_t state_r, state_nxt;
	logic [CNT_W-1:0] tmr_r, tmr_nxt;
	logic [BURST_W-1:0] burst_r, burst_nxt;
	logic run_r, run_nxt;
	logic restart_r, restart_nxt;
	logic armed_r, armed_nxt;

	wrt_sync u_sync (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_raw(i_trig),
		.o_clean(clean)
	);

	function automatic logic pick_src(input wrt_src_t s, input logic [2:0] lv, input logic t);
		case (s)
			WRT_SRC_EXT: pick_src = lv[2];
			WRT_SRC_BUTTON: pick_src = lv[1];
			WRT_SRC_EVENT: pick_src = lv[0];
			WRT_SRC_INTERNAL: pick_src = t;
			default: pick_src = 1'b0;
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		sat_inc = (v == CNT_MAX) ? v : v + CNT_ONE;
	endfunction

	assign level_vec = {clean.ext, clean.button, clean.event_in};
	assign sel_level = pick_src(i_cfg.src, level_vec, int_tick);
	assign start_level = pick_src(i_cfg.start_src, level_vec, int_tick);
	assign stop_level = pick_src(i_cfg.stop_src, level_vec, int_tick);
	assign start_edge = start_level & ~start_prev_r;
	assign stop_edge = stop_level & ~stop_prev_r;
	assign int_tick = (per_r == CNT_ZERO);

	// Qualification: width measured on the falling edge, so a trigger acts at its end.
	always_comb begin
		sel_prev_nxt = sel_level;
		start_prev_nxt = start_level;
		stop_prev_nxt = stop_level;
		width_nxt = sel_level ? sat_inc(width_r) : CNT_ZERO;
		hold_nxt = (hold_r != CNT_ZERO) ? hold_r - CNT_ONE : CNT_ZERO;
		per_nxt = (per_r == CNT_ZERO) ? i_cfg.int_period : per_r - CNT_ONE;
		qual_trig = 1'b0;
		if (i_cfg.src == WRT_SRC_INTERNAL) begin
			qual_trig = int_tick && (hold_r == CNT_ZERO);
		end else if (!sel_level && sel_prev_r) begin
			if (hold_r == CNT_ZERO) begin
				qual_trig = (width_r >= i_cfg.width_min) && (width_r <= i_cfg.width_max);
			end
		end
		if (qual_trig) begin
			hold_nxt = i_cfg.holdoff;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			sel_prev_r <= 1'b0;
			start_prev_r <= 1'b0;
			stop_prev_r <= 1'b0;
			width_r <= CNT_ZERO;
			hold_r <= CNT_ZERO;
			per_r <= CNT_ZERO;
		end else begin
			sel_prev_r <= sel_prev_nxt;
			start_prev_r <= start_prev_nxt;
			stop_prev_r <= stop_prev_nxt;
			width_r <= width_nxt;
			hold_r <= hold_nxt;
			per_r <= per_nxt;
		end
	end

	// Run state machine
	always_comb begin
		state_nxt = state_r;
		tmr_nxt = tmr_r;
		burst_nxt = burst_r;
		run_nxt = run_r;
		restart_nxt = 1'b0;
		armed_nxt = armed_r;
		case (state_r)
			ST_IDLE: begin
				run_nxt = 1'b0;
				if (i_cfg.mode == WRT_MODE_CONT) begin
					run_nxt = 1'b1;
					restart_nxt = 1'b1;
					state_nxt = ST_RUN;
				end else if (i_cfg.mode == WRT_MODE_GATED) begin
					if (sel_level == i_cfg.gate_level) begin
						run_nxt = 1'b1;
						restart_nxt = 1'b1;
						state_nxt = ST_RUN;
					end
				end else if (i_cfg.mode == WRT_MODE_ARMED) begin
					armed_nxt = i_remote_arm | armed_r;
					if (armed_r && start_edge) begin
						run_nxt = 1'b1;
						restart_nxt = 1'b1;
						state_nxt = ST_WAIT_STOP;
					end
				end else if (qual_trig || (i_cfg.mode == WRT_MODE_BURST && i_remote_trig)) begin
					burst_nxt = i_cfg.burst_count;
					if (i_cfg.delay_en && qual_trig) begin
						tmr_nxt = i_cfg.delay;
						state_nxt = ST_DELAY;
					end else begin
						run_nxt = 1'b1;
						restart_nxt = 1'b1;
						state_nxt = ST_RUN;
					end
				end
			end
			ST_DELAY: begin
				if (tmr_r == CNT_ZERO) begin
					run_nxt = 1'b1;
					restart_nxt = 1'b1;
					state_nxt = ST_RUN;
				end else begin
					tmr_nxt = tmr_r - CNT_ONE;
				end
			end
			ST_RUN: begin
				if (i_cfg.mode == WRT_MODE_GATED) begin
					if (sel_level != i_cfg.gate_level) begin
						run_nxt = 1'b0;
						state_nxt = ST_IDLE;
					end
				end else if (i_cfg.mode == WRT_MODE_OVERRIDE && qual_trig) begin
					restart_nxt = 1'b1;
				end else if (i_cycle_end) begin
					if (i_cfg.mode == WRT_MODE_BURST && burst_r > BURST_ONE) begin
						burst_nxt = burst_r - BURST_ONE;
					end else if (i_cfg.mode == WRT_MODE_RETRIG) begin
						run_nxt = 1'b0;
						tmr_nxt = i_cfg.retrig_gap;
						state_nxt = ST_GAP;
					end else if (i_cfg.mode != WRT_MODE_CONT) begin
						run_nxt = 1'b0;
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_GAP: begin
				if (tmr_r == CNT_ZERO) begin
					state_nxt = ST_IDLE;
				end else begin
					tmr_nxt = tmr_r - CNT_ONE;
				end
			end
			ST_WAIT_STOP: begin
				if (stop_edge || i_cfg.mode != WRT_MODE_ARMED) begin
					run_nxt = 1'b0;
					armed_nxt = 1'b0;
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				run_nxt = 1'b0;
				state_nxt = ST_IDLE;
			end
		endcase
		if (i_cfg.mode != WRT_MODE_ARMED) begin
			armed_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			state_r <= ST_IDLE;
			tmr_r <= CNT_ZERO;
			burst_r <= BURST_ONE;
			run_r <= 1'b0;
			restart_r <= 1'b0;
			armed_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			tmr_r <= tmr_nxt;
			burst_r <= burst_nxt;
			run_r <= run_nxt;
			restart_r <= restart_nxt;
			armed_r <= armed_nxt;
		end
	end

	assign o_run = run_r;
	assign o_restart = restart_r;
	assign o_busy = (state_r != ST_IDLE);
	assign o_armed = armed_r;

	a_override_restart: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_r == ST_RUN && i_cfg.mode == WRT_MODE_OVERRIDE && qual_trig) |=> o_restart && o_run)
		else $error("override trigger did not restart");
	a_retrig_gap: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_r == ST_GAP) |-> !o_run)
		else $error("output ran during retrigger gap");
	a_gate_stop: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_r == ST_RUN && i_cfg.mode == WRT_MODE_GATED && sel_level != i_cfg.gate_level)
		|=> !o_run)
		else $error("gated output did not stop");
	a_burst_count: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_r == ST_RUN && i_cfg.mode == WRT_MODE_BURST && i_cycle_end && burst_r > BURST_ONE)
		|=> o_run && burst_r == $past(burst_r) - BURST_ONE)
		else $error("burst count wrong");
	a_delay_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_r == ST_DELAY && tmr_r != CNT_ZERO) |=> !o_run)
		else $error("output started before delay expired");
	a_width_reject: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(i_cfg.src != WRT_SRC_INTERNAL && (width_r < i_cfg.width_min || width_r > i_cfg.width_max))
		|-> !qual_trig)
		else $error("pulse outside width window accepted");
	a_holdoff_block: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(hold_r != CNT_ZERO) |-> !qual_trig)
		else $error("trigger accepted in hold-off");
	a_armed_start: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_r == ST_IDLE && i_cfg.mode == WRT_MODE_ARMED && !armed_r) |=> !o_run)
		else $error("armed start without arm");
endmodule
`default_nettype wire

// >>> design/wrt_pkg.sv
// Package for the waveform run and trigger controller.
// Assumes one sample-domain clock and synchronous reset.
package wrt_pkg;
	localparam int CNT_W = 16;
	localparam int BURST_W = 16;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [BURST_W-1:0] BURST_ONE = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	localparam int SYNC_DEPTH = 2;
	localparam int CFG_DEPTH = 8;
	localparam int CFG_AW = 3;

	typedef enum logic [2:0] {
		WRT_MODE_CONT,
		WRT_MODE_OVERRIDE,
		WRT_MODE_RETRIG,
		WRT_MODE_GATED,
		WRT_MODE_BURST,
		WRT_MODE_ARMED
	} wrt_mode_t;

	typedef enum logic [1:0] {
		WRT_SRC_EXT,
		WRT_SRC_BUTTON,
		WRT_SRC_EVENT,
		WRT_SRC_INTERNAL
	} wrt_src_t;

	typedef struct packed {
		wrt_mode_t mode;
		wrt_src_t src;
		wrt_src_t start_src;
		wrt_src_t stop_src;
		logic gate_level;
		logic delay_en;
		logic [CNT_W-1:0] width_min;
		logic [CNT_W-1:0] width_max;
		logic [CNT_W-1:0] holdoff;
		logic [CNT_W-1:0] delay;
		logic [CNT_W-1:0] retrig_gap;
		logic [CNT_W-1:0] int_period;
		logic [BURST_W-1:0] burst_count;
	} wrt_cfg_t;

	typedef struct packed {
		logic ext;
		logic button;
		logic event_in;
	} wrt_trig_in_t;
endpackage

// >>> design/wrt_sync.sv
// Two-stage synchroniser bank for the trigger inputs.
// Assumes inputs are level signals from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module wrt_sync (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// Raw and clean inputs
	input wire wrt_pkg::wrt_trig_in_t i_raw,
	output wrt_pkg::wrt_trig_in_t o_clean
);
	import wrt_pkg::*;
	wrt_trig_in_t meta_r, meta_nxt, clean_r, clean_nxt;

	always_comb begin
		meta_nxt = i_raw;
		clean_nxt = meta_r;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			meta_r <= '0;
			clean_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			clean_r <= clean_nxt;
		end
	end

	assign o_clean = clean_r;
endmodule
`default_nettype wire

// >>> tb/wrt_ctrl_tb_top.sv
// Self-checking bench for the run and trigger controller.
// Assumes the source model in tb/ and the design package.
`timescale 1ns/1ps
`default_nettype none
module wrt_ctrl_tb_top;
	import wrt_pkg::*;
	logic i_ref_clk, i_reset, i_cycle_end, o_run, o_restart, o_busy, o_armed;
	logic rem_trig, rem_arm;
	wrt_cfg_t cfg;
	wrt_trig_in_t trig;
	int num_errors = 0, check_count = 0, cyc = 0, n, g, e;
	int wl[5] = '{1, 2, 6, 7, 0};
	int rs_q[$];
	wrt_ctrl i_wrt_ctrl (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_cfg(cfg),
		.i_trig(trig), .i_remote_trig(rem_trig), .i_remote_arm(rem_arm),
		.i_cycle_end(i_cycle_end), .o_run(o_run), .o_restart(o_restart),
		.o_busy(o_busy), .o_armed(o_armed));
	wrt_src_model i_wrt_src_model (.i_ref_clk(i_ref_clk), .o_trig(trig),
		.o_remote_trig(rem_trig), .o_remote_arm(rem_arm));
	initial begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	// Hang guard, far above the several hundred cycles needed
	always @(posedge i_ref_clk) begin
		cyc++;
		if (o_restart === 1'b1) rs_q.push_back(cyc);
		if (cyc == 8000) begin
			num_errors++;
			$display("BAD %0t timeout", $time);
			results();
		end
	end
	task automatic results();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk_int(input int got, input int exp, input string m);
		check_count++;
		if (got != exp) begin
			num_errors++;
			$display("BAD %0t %s got %0d exp %0d", $time, m, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string m);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %s got %b exp %b", $time, m, got, exp);
		end
	endtask
	// Edges until restart (rs) or run equals v; 0 when the bound runs out
	task automatic wt(input bit rs, input logic v, input int lim, output int k);
		k = 0;
		for (int i = 1; i <= lim && k == 0; i++) begin
			@(posedge i_ref_clk);
			#1;
			if ((rs ? o_restart : o_run) === v) k = i;
		end
	endtask
	task automatic cend();
		@(negedge i_ref_clk);
		i_cycle_end = 1'b1;
		@(negedge i_ref_clk);
		i_cycle_end = 1'b0;
		@(posedge i_ref_clk);
		#1;
	endtask
	// Mode, source, hold-off, delay and gap only change under reset, so they are static to the design
	task automatic setup(input wrt_mode_t m, input wrt_src_t s, input int ho, dl, gp);
		@(negedge i_ref_clk);
		i_reset = 1'b1;
		cfg.mode = m;
		cfg.src = s;
		cfg.holdoff = 16'(ho);
		cfg.delay = 16'(dl);
		cfg.delay_en = (dl != 0);
		cfg.retrig_gap = 16'(gp);
		repeat (2) @(negedge i_ref_clk);
		i_reset = 1'b0;
		rs_q.delete();
	endtask
	task automatic hit(input wrt_src_t s, input int w, input int lim);
		i_wrt_src_model.pulse(s, w);
		wt(1'b1, 1'b1, lim, n);
	endtask
	initial begin
		i_reset = 1'b1;
		i_cycle_end = 1'b0;
		cfg = '0;
		cfg.width_min = 16'h0002;
		cfg.width_max = 16'h0006;
		cfg.gate_level = 1'b1;
		cfg.burst_count = 16'h0001;
		void'($urandom(32'h0d31));
		repeat (10) @(negedge i_ref_clk);
		wl[4] = 2 + $urandom_range(4);
		for (int si = 0; si < 3; si++) begin
			setup(WRT_MODE_BURST, wrt_src_t'(si[1:0]), 0, 0, 0);
			foreach (wl[j]) begin
				hit(wrt_src_t'(si[1:0]), wl[j], 12);
				e = (wl[j] >= 2 && wl[j] <= 6) ? 3 : 0;
				chk_int(n, e, "width window");
				if (n != 0) begin
					cend();
					chk_bit(o_run, 1'b0, "single cycle stop");
					chk_bit(o_busy, 1'b0, "idle after stop");
				end
			end
			hit(wrt_src_t'(2'((si + 1) % 3)), 3, 12);
			chk_int(n, 0, "unselected source");
		end
		$display("test sources done");
		cfg.burst_count = 16'h0003;
		setup(WRT_MODE_BURST, WRT_SRC_EXT, 0, 0, 0);
		i_wrt_src_model.cmd(1'b0);
		wt(1'b0, 1'b1, 6, n);
		chk_int(n, 1, "remote burst");
		chk_int(rs_q.size(), 1, "remote restart");
		for (int c = 0; c < 3; c++) begin
			cend();
			chk_bit(o_run, logic'(c < 2), "burst count");
		end
		cfg.burst_count = 16'h0001;
		$display("test burst done");
		setup(WRT_MODE_OVERRIDE, WRT_SRC_EXT, 0, 0, 0);
		hit(WRT_SRC_EXT, 3, 12);
		hit(WRT_SRC_EXT, 3, 12);
		chk_int(n, 3, "override restart");
		chk_bit(o_run, 1'b1, "override run");
		setup(WRT_MODE_OVERRIDE, WRT_SRC_EXT, 40, 0, 0);
		hit(WRT_SRC_EXT, 3, 12);
		hit(WRT_SRC_EXT, 3, 12);
		chk_int(n, 0, "hold-off reject");
		repeat (40) @(negedge i_ref_clk);
		hit(WRT_SRC_EXT, 3, 12);
		chk_int(n, 3, "after hold-off");
		$display("test override done");
		g = 5 + $urandom_range(20);
		setup(WRT_MODE_OVERRIDE, WRT_SRC_EXT, 0, g, 0);
		hit(WRT_SRC_EXT, 3, 60);
		chk_int(n, g + 4, "delayed start");
		$display("test delay done");
		g = 20 + $urandom_range(10);
		setup(WRT_MODE_RETRIG, WRT_SRC_EXT, 0, 0, g);
		hit(WRT_SRC_EXT, 3, 12);
		cend();
		chk_bit(o_run, 1'b0, "stop at finish");
		chk_bit(o_busy, 1'b1, "busy in gap");
		hit(WRT_SRC_EXT, 3, 12);
		chk_int(n, 0, "inside gap");
		repeat (g) @(negedge i_ref_clk);
		hit(WRT_SRC_EXT, 3, 12);
		chk_int(n, 3, "after gap");
		$display("test retrigger done");
		setup(WRT_MODE_GATED, WRT_SRC_EXT, 0, 0, 0);
		i_wrt_src_model.lvl(WRT_SRC_EXT, 1'b1);
		wt(1'b0, 1'b1, 10, n);
		chk_int(n, 3, "gate start");
		repeat (20) @(negedge i_ref_clk);
		chk_bit(o_run, 1'b1, "gate held");
		i_wrt_src_model.lvl(WRT_SRC_EXT, 1'b0);
		wt(1'b0, 1'b0, 10, n);
		chk_int(n, 3, "gate stop");
		chk_bit(o_run, 1'b0, "gate left");
		$display("test gated done");
		g = 3 + $urandom_range(8);
		cfg.int_period = 16'(g);
		setup(WRT_MODE_OVERRIDE, WRT_SRC_INTERNAL, 0, 0, 0);
		repeat (4 * g + 12) @(negedge i_ref_clk);
		chk_bit(logic'(rs_q.size() >= 3), 1'b1, "internal ticks");
		if (rs_q.size() >= 3) chk_int(rs_q[2] - rs_q[1], g + 1, "tick period");
		$display("test internal done");
		cfg.start_src = WRT_SRC_EXT;
		cfg.stop_src = WRT_SRC_EVENT;
		setup(WRT_MODE_ARMED, WRT_SRC_EXT, 0, 0, 0);
		i_wrt_src_model.pulse(WRT_SRC_EXT, 3);
		repeat (12) @(negedge i_ref_clk);
		chk_bit(o_run, 1'b0, "start unarmed");
		i_wrt_src_model.cmd(1'b1);
		repeat (2) @(negedge i_ref_clk);
		chk_bit(o_armed, 1'b1, "armed");
		i_wrt_src_model.pulse(WRT_SRC_EXT, 3);
		wt(1'b0, 1'b1, 12, n);
		chk_bit(o_run, 1'b1, "armed start");
		i_wrt_src_model.pulse(WRT_SRC_EVENT, 3);
		wt(1'b0, 1'b0, 12, n);
		chk_bit(o_run | o_armed, 1'b0, "armed stop");
		$display("test armed done");
		results();
	end
endmodule
`default_nettype wire

// >>> tb/wrt_src_model.sv
// Far-side model: trigger source pins and remote host commands.
// Assumes the bench calls its tasks from one sequence at a time.
`timescale 1ns/1ps
`default_nettype none
module wrt_src_model (
	// Clock
	input wire logic i_ref_clk,
	// Source side
	output wrt_pkg::wrt_trig_in_t o_trig,
	output logic o_remote_trig,
	output logic o_remote_arm
);
	import wrt_pkg::*;
	initial begin
		o_trig = '0;
		o_remote_trig = 1'b0;
		o_remote_arm = 1'b0;
	end
	// Levels move on the falling edge, well away from sampling
	task automatic lvl(input wrt_src_t s, input logic v);
		@(negedge i_ref_clk);
		case (s)
			WRT_SRC_EXT: o_trig.ext = v;
			WRT_SRC_BUTTON: o_trig.button = v;
			default: o_trig.event_in = v;
		endcase
	endtask
	// High for exactly w sampling edges
	task automatic pulse(input wrt_src_t s, input int w);
		lvl(s, 1'b1);
		repeat (w - 1) @(negedge i_ref_clk);
		lvl(s, 1'b0);
	endtask
	// One-cycle remote command
	task automatic cmd(input bit arm);
		@(negedge i_ref_clk);
		o_remote_arm = arm;
		o_remote_trig = !arm;
		@(negedge i_ref_clk);
		o_remote_arm = 1'b0;
		o_remote_trig = 1'b0;
	endtask
endmodule
`default_nettype wire
